// file: src/iso_irq_regs.vh
// Register offsets, field positions and reset values of the isochronous context interrupt block.
`ifndef ISO_IRQ_REGS_VH
`define ISO_IRQ_REGS_VH

// Byte offsets of the per-context event and mask registers.
`define ISO_TX_EVENT_SET     8'h90
`define ISO_TX_EVENT_CLEAR   8'h94
`define ISO_TX_MASK_SET      8'h98
`define ISO_TX_MASK_CLEAR    8'h9c
`define ISO_RX_EVENT_SET     8'ha0
`define ISO_RX_EVENT_CLEAR   8'ha4
`define ISO_RX_MASK_SET      8'ha8
`define ISO_RX_MASK_CLEAR    8'hac

// Main summary status and mask register, and the local interrupt status and mask pair.
`define ISO_SUMMARY_STATUS   8'hc0
`define ISO_SUMMARY_MASK     8'hc4
`define ISO_IRQ_STATUS       8'hc8
`define ISO_IRQ_MASK         8'hcc

// Summary bit positions in the main event register layout.
`define ISO_TX_SUMMARY_BIT   6
`define ISO_RX_SUMMARY_BIT   7

// Local status bits: one per summary source.
`define ISO_IRQ_TX_BIT       0
`define ISO_IRQ_RX_BIT       1

// Reset values of flags and masks.
`define ISO_TX_FLAG_RESET    8'h00
`define ISO_RX_FLAG_RESET    4'h0
`define ISO_TX_MASK_RESET    8'h00
`define ISO_RX_MASK_RESET    4'h0

`endif

// file: src/iso_context_irq_event_mask.v
// Per-context isochronous interrupt event and mask registers with summary interrupt generation.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "iso_irq_regs.vh"

// Notes on behaviour
// R01: A transmit context flag rises when its last output descriptor finishes with interrupt bits set.
// R02: A receive context flag rises when any input descriptor finishes with interrupt bits set.
// R03: A flag becomes one on a rising edge of its context pulse or on a one written to the set register.
// R04: A flag is cleared only by a one written to the clear register, never by hardware.
// R05: Reading the transmit event clear address returns the transmit flags ANDed with the transmit mask.
// R06: Reading the receive event clear address returns the receive flags ANDed with the receive mask.
// R07: The transmit event register holds eight flags in bits 7 to 0, and bits 31 to 8 read zero.
// R08: The receive event register holds four flags in bits 3 to 0, and bits 31 to 4 read zero.
// R09: The transmit mask has one enable per context, set and cleared through its own set and clear addresses.
// R10: The receive mask has one enable per context, set and cleared through its own set and clear addresses.
// R11: Reading either mask address returns the unmodified mask contents.
// R12: Transmit context interrupts are reported through summary bit 6 of the main event register.
// R13: Receive context interrupts are reported through summary bit 7 of the main event register.
// R14: After reset the receive mask is zero and the upper bits of both event registers are zero.
// R15: A summary interrupt reaches the host only when its summary event bit and main mask bit are both one; irq_o follows sticky irq_status & irq_mask.
// R16: A summary event is asserted while any flag ANDed with its mask bit is one.
// R17: Zero bits written to a set or clear register leave flags and masks unchanged.
module iso_context_irq_event_mask #(
    parameter TX_CTX = 8,
    parameter RX_CTX = 4
) (
    // Clock and reset.
    input  wire        clk_i,
    input  wire        nrst_i,
    // Register port.
    input  wire [7:0]  addr_i,
    input  wire [31:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [31:0] rdata_o,
    // Context completion pulses, already qualified by the descriptor interrupt bits.
    input  wire [TX_CTX-1:0] tx_ctx_irq_i,
    input  wire [RX_CTX-1:0] rx_ctx_irq_i,
    // Summary events and host interrupt.
    output reg         tx_summary_event_o,
    output reg         rx_summary_event_o,
    output reg         irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // State.
    reg [TX_CTX-1:0] tx_flag;
    reg [RX_CTX-1:0] rx_flag;
    reg [TX_CTX-1:0] tx_mask;
    reg [RX_CTX-1:0] rx_mask;
    reg [TX_CTX-1:0] tx_irq_q;
    reg [RX_CTX-1:0] rx_irq_q;
    reg [1:0]        summary_mask;
    reg [1:0]        irq_status;
    reg [1:0]        irq_mask;
    reg [31:0]       next_rdata;

    wire [TX_CTX-1:0] tx_rise;
    wire [RX_CTX-1:0] rx_rise;
    wire              tx_any;
    wire              rx_any;
    wire              tx_host;
    wire              rx_host;
    wire [1:0]        next_status;

    // Returns one when a write strobe hits the given offset.
    function wr_hit;
        input [7:0] off;
        begin
            wr_hit = wr_i && (addr_i == off);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection of the context pulses and summary terms.
    assign tx_rise = tx_ctx_irq_i & ~tx_irq_q; // R01 R03
    assign rx_rise = rx_ctx_irq_i & ~rx_irq_q; // R02 R03
    assign tx_any  = |(tx_flag & tx_mask);     // R16 R12
    assign rx_any  = |(rx_flag & rx_mask);     // R16 R13
    assign tx_host = tx_any & summary_mask[0]; // R15
    assign rx_host = rx_any & summary_mask[1]; // R15
    assign next_status = {rx_host, tx_host};

    // Pulse history for edge detection.
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_irq_q <= {TX_CTX{1'b0}};
            rx_irq_q <= {RX_CTX{1'b0}};
        end else begin
            tx_irq_q <= tx_ctx_irq_i;
            rx_irq_q <= rx_ctx_irq_i;
        end
    end

    // Event flags: a new edge or a set write wins over a clear in the same cycle.
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_flag <= `ISO_TX_FLAG_RESET; // R14
            rx_flag <= `ISO_RX_FLAG_RESET; // R14
        end else begin
            tx_flag <= (tx_flag & ~(wr_hit(`ISO_TX_EVENT_CLEAR) ? wdata_i[TX_CTX-1:0] : {TX_CTX{1'b0}})) // R04 R17
                       | tx_rise
                       | (wr_hit(`ISO_TX_EVENT_SET) ? wdata_i[TX_CTX-1:0] : {TX_CTX{1'b0}}); // R03 R17
            rx_flag <= (rx_flag & ~(wr_hit(`ISO_RX_EVENT_CLEAR) ? wdata_i[RX_CTX-1:0] : {RX_CTX{1'b0}})) // R04 R17
                       | rx_rise
                       | (wr_hit(`ISO_RX_EVENT_SET) ? wdata_i[RX_CTX-1:0] : {RX_CTX{1'b0}}); // R03 R17
        end
    end

    // Masks are set and cleared through their own address pair.
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_mask <= `ISO_TX_MASK_RESET;
            rx_mask <= `ISO_RX_MASK_RESET; // R14
        end else begin
            if (wr_hit(`ISO_TX_MASK_SET)) begin
                tx_mask <= tx_mask | wdata_i[TX_CTX-1:0]; // R09 R17
            end else if (wr_hit(`ISO_TX_MASK_CLEAR)) begin
                tx_mask <= tx_mask & ~wdata_i[TX_CTX-1:0]; // R09 R17
            end
            if (wr_hit(`ISO_RX_MASK_SET)) begin
                rx_mask <= rx_mask | wdata_i[RX_CTX-1:0]; // R10 R17
            end else if (wr_hit(`ISO_RX_MASK_CLEAR)) begin
                rx_mask <= rx_mask & ~wdata_i[RX_CTX-1:0]; // R10 R17
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main summary mask, sticky interrupt status and its mask.
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            summary_mask <= 2'h0;
            irq_status   <= 2'h0;
            irq_mask     <= 2'h0;
        end else begin
            if (wr_hit(`ISO_SUMMARY_MASK)) begin
                summary_mask <= {wdata_i[`ISO_RX_SUMMARY_BIT], wdata_i[`ISO_TX_SUMMARY_BIT]};
            end
            if (wr_hit(`ISO_IRQ_MASK)) begin
                irq_mask <= wdata_i[1:0];
            end
            // Setting wins over a write-one clear in the same cycle.
            irq_status <= (irq_status & ~(wr_hit(`ISO_IRQ_STATUS) ? wdata_i[1:0] : 2'h0)) | next_status;
        end
    end

    // Outputs straight from flip-flops.
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_summary_event_o <= 1'b0;
            rx_summary_event_o <= 1'b0;
            irq_o              <= 1'b0;
        end else begin
            tx_summary_event_o <= tx_any; // R12
            rx_summary_event_o <= rx_any; // R13
            irq_o              <= |(irq_status & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data select; unmapped offsets read zero.
    always @* begin
        next_rdata = 32'h0000_0000;
        case (addr_i)
            `ISO_TX_EVENT_SET:   next_rdata[TX_CTX-1:0] = tx_flag;           // R07
            `ISO_TX_EVENT_CLEAR: next_rdata[TX_CTX-1:0] = tx_flag & tx_mask; // R05
            `ISO_TX_MASK_SET,
            `ISO_TX_MASK_CLEAR:  next_rdata[TX_CTX-1:0] = tx_mask;           // R11
            `ISO_RX_EVENT_SET:   next_rdata[RX_CTX-1:0] = rx_flag;           // R08
            `ISO_RX_EVENT_CLEAR: next_rdata[RX_CTX-1:0] = rx_flag & rx_mask; // R06
            `ISO_RX_MASK_SET,
            `ISO_RX_MASK_CLEAR:  next_rdata[RX_CTX-1:0] = rx_mask;           // R11
            `ISO_SUMMARY_STATUS: begin
                next_rdata[`ISO_TX_SUMMARY_BIT] = tx_any;
                next_rdata[`ISO_RX_SUMMARY_BIT] = rx_any;
            end
            `ISO_SUMMARY_MASK: begin
                next_rdata[`ISO_TX_SUMMARY_BIT] = summary_mask[0];
                next_rdata[`ISO_RX_SUMMARY_BIT] = summary_mask[1];
            end
            `ISO_IRQ_STATUS:     next_rdata[1:0] = irq_status;
            `ISO_IRQ_MASK:       next_rdata[1:0] = irq_mask;
            default:             next_rdata = 32'h0000_0000;
        endcase
    end

    // Read data registered one cycle after the strobe, zero otherwise.
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 32'h0000_0000;
        end else begin
            rdata_o <= rd_i ? next_rdata : 32'h0000_0000;
        end
    end

endmodule // iso_context_irq_event_mask

// file: dv/iso_irq_checker_asserts.sv
// Port-level assertions for the isochronous context interrupt block.
`timescale 1ns/1ps
module iso_irq_checker #(
    parameter TX_CTX = 8,
    parameter RX_CTX = 4
) (
    // Clock, reset and register port.
    input logic              clk_i,
    input logic              nrst_i,
    input logic [7:0]        addr_i,
    input logic [31:0]       wdata_i,
    input logic              wr_i,
    input logic              rd_i,
    input logic [31:0]       rdata_o,
    // Context pulses and summary outputs.
    input logic [TX_CTX-1:0] tx_ctx_irq_i,
    input logic [RX_CTX-1:0] rx_ctx_irq_i,
    input logic              tx_summary_event_o,
    input logic              rx_summary_event_o,
    input logic              irq_o
);
    // All checks share the core clock and its reset.
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    tx_upper_zero_a: assert property ($past(rd_i) && $past(addr_i[7:4]) == 4'h9 |-> rdata_o[31:8] == 24'h0)
        else $error("tx register read shows upper bits");
    rx_upper_zero_a: assert property ($past(rd_i) && $past(addr_i[7:4]) == 4'ha |-> rdata_o[31:4] == 28'h0)
        else $error("rx register read shows upper bits");
    tx_fall_cause_a: assert property ($fell(tx_summary_event_o) |-> $past(wr_i, 2))
        else $error("tx summary fell without a write");
    rx_fall_cause_a: assert property ($fell(rx_summary_event_o) |-> $past(wr_i, 2))
        else $error("rx summary fell without a write");
    tx_rise_cause_a: assert property ($rose(tx_summary_event_o) |-> $past(wr_i, 2) || $past(tx_ctx_irq_i, 2) != 0)
        else $error("tx summary rose without a cause");
    rx_rise_cause_a: assert property ($rose(rx_summary_event_o) |-> $past(wr_i, 2) || $past(rx_ctx_irq_i, 2) != 0)
        else $error("rx summary rose without a cause");
    quiet_stable_a: assert property ((!wr_i && tx_ctx_irq_i == 0 && rx_ctx_irq_i == 0)[*2]
        |=> $stable(tx_summary_event_o) && $stable(rx_summary_event_o)) else $error("summary moved while quiet");
    irq_fall_cause_a: assert property ($fell(irq_o) |-> $past(wr_i, 2))
        else $error("interrupt fell without a write");
endmodule // iso_irq_checker

bind iso_context_irq_event_mask iso_irq_checker #(.TX_CTX(TX_CTX), .RX_CTX(RX_CTX)) u_iso_irq_checker (.clk_i,
    .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .tx_ctx_irq_i, .rx_ctx_irq_i, .tx_summary_event_o,
    .rx_summary_event_o, .irq_o);

// file: dv/test_iso_context_irq_event_mask.sv
// Self-checking bench of the isochronous context interrupt block.
`timescale 1ns/1ps
module test_iso_context_irq_event_mask;
    logic        clk_i, nrst_i, wr_i, rd_i, txs, rxs, irq_o;
    logic [7:0]  addr_i, tx_ctx_irq_i;
    logic [3:0]  rx_ctx_irq_i;
    logic [31:0] wdata_i, rdata_o, d;
    int          fails, samples_checked;

    iso_context_irq_event_mask u_iso_context_irq_event_mask (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .tx_ctx_irq_i, .rx_ctx_irq_i, .tx_summary_event_o(txs), .rx_summary_event_o(rxs), .irq_o);

    // Free-running 100 MHz clock.
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, s);
            fails++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= v;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe.
    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 chk(n, rdata_o, e);
    endtask
    task automatic t_tx();
        wr(8'h94, 32'hff);
        wr(8'h90, 32'hffffffff);
        rc("tx flags", 8'h90, 32'hff);
        wr(8'h94, 32'h1);
        rc("tx after clear", 8'h90, 32'hfe);
        wr(8'h94, 32'h0);
        wr(8'h90, 32'h0);
        rc("tx zero writes", 8'h90, 32'hfe);
        wr(8'h98, 32'h0f);
        rc("tx mask", 8'h9c, 32'h0f);
        rc("tx masked flags", 8'h94, 32'h0e);
        chk("tx summary on", {31'h0, txs}, 32'h1);
        wr(8'h9c, 32'hff);
        rc("tx mask cleared", 8'h98, 32'h0);
        chk("tx summary off", {31'h0, txs}, 32'h0);
        wr(8'h94, 32'hff);
        @(posedge clk_i);
        tx_ctx_irq_i <= 8'h80;
        @(posedge clk_i);
        tx_ctx_irq_i <= 8'h0;
        rc("tx pulse flag", 8'h90, 32'h80);
    endtask
    task automatic t_rx();
        rc("rx mask reset", 8'ha8, 32'h0);
        wr(8'ha4, 32'hf);
        rx_ctx_irq_i <= 4'h4;
        rc("rx pulse flag", 8'ha0, 32'h4);
        wr(8'ha4, 32'h4);
        rc("rx held pulse", 8'ha0, 32'h0);
        rx_ctx_irq_i <= 4'h0;
        wr(8'ha8, 32'h4);
        wr(8'ha0, 32'hffffffff);
        rc("rx flags", 8'ha0, 32'hf);
        rc("rx masked flags", 8'ha4, 32'h4);
        rc("rx mask", 8'hac, 32'h4);
        chk("rx summary", {31'h0, rxs}, 32'h1);
        rc("unmapped", 8'h10, 32'h0);
    endtask
    // Summary interrupt needs both the main mask and the local mask.
    task automatic t_irq();
        wr(8'hcc, 32'h3);
        repeat (3) @(posedge clk_i);
        #1 chk("irq main masked", {31'h0, irq_o}, 32'h0);
        wr(8'hc4, 32'hc0);
        repeat (3) @(posedge clk_i);
        #1 chk("irq raised", {31'h0, irq_o}, 32'h1);
        wr(8'hcc, 32'h0);
        repeat (3) @(posedge clk_i);
        #1 chk("irq local masked", {31'h0, irq_o}, 32'h0);
        wr(8'hac, 32'hf);
        wr(8'hc8, 32'h3);
        wr(8'hcc, 32'h3);
        repeat (3) @(posedge clk_i);
        #1 chk("irq cleared", {31'h0, irq_o}, 32'h0);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Reset for 20 cycles, then run every scenario.
    initial begin
        {nrst_i, wr_i, rd_i, addr_i, wdata_i, tx_ctx_irq_i, rx_ctx_irq_i} = '0;
        fails = 0;
        samples_checked = 0;
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        t_rx();
        t_tx();
        t_irq();
        finish_test();
    end
endmodule // test_iso_context_irq_event_mask
